// ---- inc/pmd_cfg.svh ----
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH

// Indexed configuration space: index port and data port offsets
`define PMD_PORT_INDEX      1'b0
`define PMD_PORT_DATA       1'b1

// Register indexes
`define PMD_IDX_SIG_A_LEVEL 8'hAA
`define PMD_IDX_SIG_B_LEVEL 8'hAB
`define PMD_IDX_SIG_C_LEVEL 8'hAC
`define PMD_IDX_SIG_D_LEVEL 8'hAD
`define PMD_IDX_PIN_MAP_AB  8'hAE
`define PMD_IDX_PIN_MAP_CD  8'hAF
`define PMD_IDX_EXT_INT_MAP 8'hB0

// Level register fields
`define PMD_LEV_HYPER       5
`define PMD_LEV_HIGH        4
`define PMD_LEV_LOW         3
`define PMD_LEV_TEMP_LOW    2
`define PMD_LEV_STANDBY     1
`define PMD_LEV_SUSPEND     0
`define PMD_LEV_MASK        8'h3F

// Pin map fields
`define PMD_MAP_LO_LSB      0
`define PMD_MAP_HI_LSB      4
`define PMD_MAP_DISABLED    4'hF

// External interrupt map fields
`define PMD_XMI_TYPE_BIT    4
`define PMD_XMI_MASK        8'h1F

// Reset values
`define PMD_RST_LEVEL       8'h00
`define PMD_RST_PIN_MAP     8'hFF
`define PMD_RST_EXT_INT_MAP 8'h0F

`endif

// ---- inc/pmd_pkg.sv ----
package pmd_pkg;

  typedef enum logic [2:0] {
    PMD_MODE_HYPER,
    PMD_MODE_HIGH,
    PMD_MODE_LOW,
    PMD_MODE_TEMP_LOW,
    PMD_MODE_STANDBY,
    PMD_MODE_SUSPEND,
    PMD_MODE_CRIT_SUSPEND
  } pmd_mode_t;

endpackage

// ---- design/pmd_sig_unit.sv ----
`timescale 1ns/100ps
`include "pmd_cfg.svh"

// One mode-tracking signal: latches its level on each mode entry
module pmd_sig_unit (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Mode tracking
  input  wire logic              mode_entry,
  input  wire pmd_pkg::pmd_mode_t mode,
  input  wire logic [5:0]        levels,
  // Result
  output logic                   level_q
);

  function automatic logic pick_level(input pmd_pkg::pmd_mode_t m, input logic [5:0] lv);
    logic r;
    r = 1'b0;
    case (m)
      pmd_pkg::PMD_MODE_HYPER:        r = lv[`PMD_LEV_HYPER];
      pmd_pkg::PMD_MODE_HIGH:         r = lv[`PMD_LEV_HIGH];
      pmd_pkg::PMD_MODE_LOW:          r = lv[`PMD_LEV_LOW];
      pmd_pkg::PMD_MODE_TEMP_LOW:     r = lv[`PMD_LEV_TEMP_LOW];
      pmd_pkg::PMD_MODE_STANDBY:      r = lv[`PMD_LEV_STANDBY];
      pmd_pkg::PMD_MODE_SUSPEND,
      pmd_pkg::PMD_MODE_CRIT_SUSPEND: r = lv[`PMD_LEV_SUSPEND];
      default:                        r = 1'b0;
    endcase
    return r;
  endfunction

  // Level is held between entries so later register writes do not glitch the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= 1'b0;
    end else if (ce && mode_entry) begin
      level_q <= pick_level(mode, levels);
    end
  end

endmodule

// ---- design/pmd_top.sv ----
`timescale 1ns/100ps
`include "pmd_cfg.svh"

// How it works
// - Level bit 5 gives the pin level on hyper-speed entry.
// - Level bit 4 gives the pin level on high-speed entry.
// - Level bit 3 gives the pin level on low-speed entry.
// - Level bit 2 gives the pin level on temporary low-speed entry.
// - Level bit 1 gives the pin level on standby entry.
// - Level bit 0 gives the level on suspend or critical suspend entry.
// - Critical-suspend indicator is asserted while in critical suspend.
// - Signal A goes to the pin in map AB bits 3 to 0.
// - Signal B goes to the pin in map AB bits 7 to 4.
// - Interrupt map bit 4 selects system-management (0) or non-maskable (1).
// - Falling edge on the selected pin raises that interrupt; 15 disables.
module pmd_top #(
  parameter int NUM_PINS = 15
) (
  // Clock, reset, enable
  input  wire logic                MCLK,
  input  wire logic                RST,
  input  wire logic                CE,
  // Indexed configuration port
  input  wire logic                CFG_SEL,
  input  wire logic                CFG_ADDR,
  input  wire logic                CFG_WR,
  input  wire logic                CFG_RD,
  input  wire logic [7:0]          CFG_WDATA,
  output logic      [7:0]          CFG_RDATA,
  output logic                     CFG_HIT,
  // Power manager
  input  wire pmd_pkg::pmd_mode_t  PM_MODE,
  // Chip-select pins
  input  wire logic [NUM_PINS-1:0] PIN_IN,
  output logic      [NUM_PINS-1:0] PIN_MODE_OUT,
  output logic      [NUM_PINS-1:0] PIN_MODE_OWN,
  // Status and interrupts
  output logic                     CRIT_SUSPEND_N,
  output logic                     SMI_REQ,
  output logic                     NMI_REQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] index_q;
  logic [7:0] level_q [4];
  logic [7:0] pin_map_ab_q;
  logic [7:0] pin_map_cd_q;
  logic [7:0] ext_int_map_q;
  logic       wr_data;

  assign wr_data = CE && CFG_SEL && CFG_WR && (CFG_ADDR == `PMD_PORT_DATA);

  function automatic int level_slot(input logic [7:0] idx);
    int s;
    s = -1;
    if (idx == `PMD_IDX_SIG_A_LEVEL) begin
      s = 0;
    end else if (idx == `PMD_IDX_SIG_B_LEVEL) begin
      s = 1;
    end else if (idx == `PMD_IDX_SIG_C_LEVEL) begin
      s = 2;
    end else if (idx == `PMD_IDX_SIG_D_LEVEL) begin
      s = 3;
    end
    return s;
  endfunction

  always_ff @(posedge MCLK) begin
    if (RST) begin
      index_q <= 8'h00;
    end else if (CE && CFG_SEL && CFG_WR && (CFG_ADDR == `PMD_PORT_INDEX)) begin
      index_q <= CFG_WDATA;
    end
  end

  // Reserved bits are kept in storage so read-modify-write returns them
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < 4; i++) begin
        level_q[i] <= `PMD_RST_LEVEL;
      end
    end else if (wr_data && level_slot(index_q) >= 0) begin
      level_q[level_slot(index_q)] <= CFG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_map_ab_q  <= `PMD_RST_PIN_MAP;
      pin_map_cd_q  <= `PMD_RST_PIN_MAP;
      ext_int_map_q <= `PMD_RST_EXT_INT_MAP;
    end else if (wr_data) begin
      if (index_q == `PMD_IDX_PIN_MAP_AB) begin
        pin_map_ab_q <= CFG_WDATA;
      end else if (index_q == `PMD_IDX_PIN_MAP_CD) begin
        pin_map_cd_q <= CFG_WDATA;
      end else if (index_q == `PMD_IDX_EXT_INT_MAP) begin
        ext_int_map_q <= CFG_WDATA;
      end
    end
  end

  // Read data registered; unmapped indexes read zero with no hit
  always_ff @(posedge MCLK) begin
    if (RST) begin
      CFG_RDATA <= 8'h00;
      CFG_HIT   <= 1'b0;
    end else if (CE) begin
      CFG_RDATA <= 8'h00;
      CFG_HIT   <= 1'b0;
      if (CFG_SEL && CFG_RD) begin
        CFG_HIT <= 1'b1;
        if (CFG_ADDR == `PMD_PORT_INDEX) begin
          CFG_RDATA <= index_q;
        end else if (level_slot(index_q) >= 0) begin
          CFG_RDATA <= level_q[level_slot(index_q)];
        end else if (index_q == `PMD_IDX_PIN_MAP_AB) begin
          CFG_RDATA <= pin_map_ab_q;
        end else if (index_q == `PMD_IDX_PIN_MAP_CD) begin
          CFG_RDATA <= pin_map_cd_q;
        end else if (index_q == `PMD_IDX_EXT_INT_MAP) begin
          CFG_RDATA <= ext_int_map_q & `PMD_XMI_MASK;
        end else begin
          CFG_HIT <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode tracking

  pmd_pkg::pmd_mode_t mode_q;
  logic               seen_q;
  logic               mode_entry;

  // First cycle after reset counts as an entry so pins take a defined level
  assign mode_entry = !seen_q || (PM_MODE != mode_q);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      mode_q <= pmd_pkg::PMD_MODE_HIGH;
      seen_q <= 1'b0;
    end else if (CE) begin
      mode_q <= PM_MODE;
      seen_q <= 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      CRIT_SUSPEND_N <= 1'b1;
    end else if (CE) begin
      CRIT_SUSPEND_N <= (PM_MODE != pmd_pkg::PMD_MODE_CRIT_SUSPEND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signal units and pin routing

  logic [3:0] sig_level;
  logic [3:0] sig_pin_select [4];

  assign sig_pin_select[0] = pin_map_ab_q[`PMD_MAP_LO_LSB +: 4];
  assign sig_pin_select[1] = pin_map_ab_q[`PMD_MAP_HI_LSB +: 4];
  assign sig_pin_select[2] = pin_map_cd_q[`PMD_MAP_LO_LSB +: 4];
  assign sig_pin_select[3] = pin_map_cd_q[`PMD_MAP_HI_LSB +: 4];

  for (genvar g = 0; g < 4; g++) begin : g_sig
    pmd_sig_unit u_sig (
      .clk        (MCLK),
      .rst        (RST),
      .ce         (CE),
      .mode_entry (mode_entry),
      .mode       (PM_MODE),
      .levels     (level_q[g][5:0]),
      .level_q    (sig_level[g])
    );
  end

  // On a shared pin the later signal (D over C over B over A) wins
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PIN_MODE_OUT <= '0;
      PIN_MODE_OWN <= '0;
    end else if (CE) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        PIN_MODE_OUT[p] <= 1'b0;
        PIN_MODE_OWN[p] <= 1'b0;
        for (int s = 0; s < 4; s++) begin
          if (sig_pin_select[s] != `PMD_MAP_DISABLED && 32'(sig_pin_select[s]) == p) begin
            PIN_MODE_OUT[p] <= sig_level[s];
            PIN_MODE_OWN[p] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt input

  logic [3:0] int_pin_select;
  logic       int_sample_q;
  logic       int_valid_q;
  logic       int_level;

  assign int_pin_select = ext_int_map_q[3:0];
  assign int_level = (int_pin_select == `PMD_MAP_DISABLED) ? 1'b1 : PIN_IN[int_pin_select];

  // Valid flag stops a remap from faking an edge on the first sample
  always_ff @(posedge MCLK) begin
    if (RST) begin
      int_sample_q <= 1'b1;
      int_valid_q  <= 1'b0;
    end else if (CE) begin
      int_sample_q <= int_level;
      int_valid_q  <= !(wr_data && index_q == `PMD_IDX_EXT_INT_MAP);
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      SMI_REQ <= 1'b0;
      NMI_REQ <= 1'b0;
    end else if (CE) begin
      SMI_REQ <= 1'b0;
      NMI_REQ <= 1'b0;
      if (int_valid_q && int_sample_q && !int_level) begin
        if (ext_int_map_q[`PMD_XMI_TYPE_BIT]) begin
          NMI_REQ <= 1'b1;
        end else begin
          SMI_REQ <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- dv/pmd_top_chk.sv ----
`timescale 1ns/100ps
module pmd_top_chk #(
  parameter int NUM_PINS = 15
) (
  // Clock, reset, config port
  input wire logic                MCLK,
  input wire logic                RST,
  input wire logic                CE,
  input wire logic                CFG_SEL,
  input wire logic                CFG_WR,
  input wire logic                CFG_RD,
  input wire logic [7:0]          CFG_RDATA,
  input wire logic                CFG_HIT,
  // Mode, pins, status
  input wire pmd_pkg::pmd_mode_t  PM_MODE,
  input wire logic [NUM_PINS-1:0] PIN_IN,
  input wire logic [NUM_PINS-1:0] PIN_MODE_OUT,
  input wire logic [NUM_PINS-1:0] PIN_MODE_OWN,
  input wire logic                CRIT_SUSPEND_N,
  input wire logic                SMI_REQ,
  input wire logic                NMI_REQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  ////////////////////////////////
  property p_rst_quiet;
    $fell(RST) |-> PIN_MODE_OWN == '0 && CRIT_SUSPEND_N && !SMI_REQ && !NMI_REQ;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_crit_on;
    CE && PM_MODE == pmd_pkg::PMD_MODE_CRIT_SUSPEND |=> !CRIT_SUSPEND_N;
  endproperty
  a_crit_on: assert property (p_crit_on) else $error("indicator missing");
  property p_crit_off;
    CE && PM_MODE != pmd_pkg::PMD_MODE_CRIT_SUSPEND |=> CRIT_SUSPEND_N;
  endproperty
  a_crit_off: assert property (p_crit_off) else $error("indicator stuck");
  property p_rd_idle;
    CE && !(CFG_SEL && CFG_RD) |=> CFG_RDATA == 8'h00 && !CFG_HIT;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  // Map writes may reroute, so only quiet stretches are held to stability
  property p_pins_hold;
    (CE && $stable(PM_MODE) && !(CFG_SEL && CFG_WR)) [*3] |=>
      $stable(PIN_MODE_OUT) && $stable(PIN_MODE_OWN);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pin moved without entry");
  property p_irq_excl;
    !(SMI_REQ && NMI_REQ);
  endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("both interrupt kinds");
  property p_irq_pulse;
    SMI_REQ || NMI_REQ |=> !SMI_REQ && !NMI_REQ;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("request too long");
  property p_irq_cause;
    SMI_REQ || NMI_REQ |-> (|($past(PIN_IN, 2) & ~$past(PIN_IN)))
      || (|($past(PIN_IN, 3) & ~$past(PIN_IN, 2)));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without edge");
endmodule

bind pmd_top pmd_top_chk #(.NUM_PINS(NUM_PINS)) chk_u (.MCLK, .RST, .CE, .CFG_SEL, .CFG_WR,
  .CFG_RD, .CFG_RDATA, .CFG_HIT, .PM_MODE, .PIN_IN, .PIN_MODE_OUT, .PIN_MODE_OWN,
  .CRIT_SUSPEND_N, .SMI_REQ, .NMI_REQ);

// ---- dv/pmd_pin_partner.sv ----
`timescale 1ns/100ps
// Far-side logic on the pins; lines idle high on their pull-ups
module pmd_pin_partner #(
  parameter int NUM_PINS = 15
) (
  // From the bench
  input wire logic                MCLK,
  input wire logic                fire,
  input wire logic [3:0]          pin_sel,
  input wire logic [3:0]          low_len,
  // Pin drive
  output logic     [NUM_PINS-1:0] pins
);
  initial pins = '1;
  // Held low for low_len edges so a slow sampler still sees the fall
  always @(posedge MCLK) begin
    if (fire && pin_sel < NUM_PINS) begin
      #1 pins[pin_sel] = 1'b0;
      repeat (low_len) @(posedge MCLK);
      #1 pins = '1;
    end
  end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        crit_e = 1'b1;
  logic        sel = 1'b0, adr = 1'b0, wr_s = 1'b0, rd_s = 1'b0, look = 1'b0, fire = 1'b0;
  logic [7:0]  wdata = 8'h00, rdata, mab = 8'hFF, mcd = 8'hFF;
  logic        hit, crit_n, smi, nmi;
  logic [2:0]  mi = 3'h0;
  logic [3:0]  psel = 4'h0, plen = 4'h1;
  logic [14:0] pout, pown, ppins, pin_w;
  logic [7:0]  lev [4];
  logic        lat [4];
  logic [29:0] rd_q[$], pin_q[$], irq_q[$], crit_q[$];
  int          num_errors = 0, samples_checked = 0;

  always #50 mclk = ~mclk;
  // Owned pins carry the block's level, the rest the far side's
  assign pin_w = (pown & pout) | (~pown & ppins);

  pmd_top #(.NUM_PINS(15)) dut_u (.MCLK(mclk), .RST(rst), .CE(ce), .CFG_SEL(sel),
    .CFG_ADDR(adr), .CFG_WR(wr_s), .CFG_RD(rd_s), .CFG_WDATA(wdata), .CFG_RDATA(rdata),
    .CFG_HIT(hit), .PM_MODE(pmd_pkg::pmd_mode_t'(mi)), .PIN_IN(pin_w), .PIN_MODE_OUT(pout),
    .PIN_MODE_OWN(pown), .CRIT_SUSPEND_N(crit_n), .SMI_REQ(smi), .NMI_REQ(nmi));
  pmd_pin_partner #(.NUM_PINS(15)) far_u (.MCLK(mclk), .fire(fire), .pin_sel(psel),
    .low_len(plen), .pins(ppins));
  ////////////////////////////////
  function automatic void cmp(input string n, input logic [29:0] e, input logic [29:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s: expected %h seen %h", n, e, s);
    end
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic rd_it = 1'b0);
    step();
    sel = 1'b1;
    adr = 1'b0;
    wr_s = 1'b1;
    wdata = idx;
    step();
    adr = 1'b1;
    wdata = d;
    wr_s = !rd_it;
    rd_s = rd_it;
    step();
    wr_s = 1'b0;
    rd_s = 1'b0;
    sel = 1'b0;
  endtask
  task automatic chk_pins();
    logic [14:0] o;
    logic [14:0] w;
    logic [3:0]  c;
    o = '0;
    w = '0;
    for (int s = 0; s < 4; s++) begin
      c = s[1] ? (s[0] ? mcd[7:4] : mcd[3:0]) : (s[0] ? mab[7:4] : mab[3:0]);
      if (c != 4'hF) begin
        w[c] = 1'b1;
        o[c] = lat[s];
      end
    end
    pin_q.push_back({w, o});
    crit_q.push_back(30'(crit_e));
    step();
    look = 1'b1;
    step();
    look = 1'b0;
  endtask
  // Results are matched to notes in the order they were made
  always @(negedge mclk) begin
    if (hit === 1'b1)
      cmp("rdata", rd_q.size() ? rd_q.pop_front() : 'x, 30'(rdata));
    if (look) begin
      cmp("pins", pin_q.pop_front(), {pown, pout});
      cmp("crit", crit_q.pop_front(), 30'(crit_n));
    end
    if (smi === 1'b1 || nmi === 1'b1)
      cmp("irq", irq_q.size() ? irq_q.pop_front() : 'x, 30'({nmi, smi}));
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    logic [3:0] c;
    void'($urandom(32'h7B18));
    for (int s = 0; s < 4; s++) begin
      lev[s] = 8'h00;
      lat[s] = 1'b0;
    end
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd_q.push_back(i < 4 ? 30'h00 : (i == 6 ? 30'h0F : 30'hFF));
      wr(8'hAA + 8'(i), 8'h00, 1'b1);
    end
    wr(8'hB1, 8'h5A);
    wr(8'hB1, 8'h00, 1'b1);
    // Index port reads back the last index written
    rd_q.push_back(30'h0B1);
    step();
    sel = 1'b1;
    adr = 1'b0;
    rd_s = 1'b1;
    step();
    rd_s = 1'b0;
    sel = 1'b0;
    $display("register reset test done");
    for (int i = 0; i < 24; i++) begin
      for (int s = 0; s < 4; s++) begin
        lev[s] = 8'($urandom);
        wr(8'hAA + 8'(s), lev[s]);
      end
      mab = 8'($urandom);
      mcd = 8'($urandom);
      wr(8'hAE, mab);
      wr(8'hAF, mcd);
      rd_q.push_back(30'(lev[i % 4]));
      wr(8'hAA + 8'(i % 4), 8'h00, 1'b1);
      step();
      mi = 3'((int'(mi) + $urandom_range(6, 1)) % 7);
      for (int s = 0; s < 4; s++)
        lat[s] = lev[s][mi >= 3'd5 ? 0 : 5 - mi];
      crit_e = (mi != 3'(pmd_pkg::PMD_MODE_CRIT_SUSPEND));
      step();
      chk_pins();
      lev[i % 4] = ~lev[i % 4];
      wr(8'hAA + 8'(i % 4), lev[i % 4]);
      chk_pins();
    end
    $display("mode pin test done");
    // Clock enable low must freeze pins and indicator across a mode change
    ce = 1'b0;
    mi = 3'((int'(mi) + $urandom_range(6, 1)) % 7);
    step();
    chk_pins();
    ce = 1'b1;
    for (int s = 0; s < 4; s++)
      lat[s] = lev[s][mi >= 3'd5 ? 0 : 5 - mi];
    crit_e = (mi != 3'(pmd_pkg::PMD_MODE_CRIT_SUSPEND));
    step();
    chk_pins();
    $display("clock enable test done");
    mab = 8'hFF;
    mcd = 8'hFF;
    wr(8'hAE, mab);
    wr(8'hAF, mcd);
    for (int t = 0; t < 5; t++) begin
      c = t == 4 ? 4'hF : 4'($urandom_range(14));
      wr(8'hB0, {3'h0, t[0], c});
      rd_q.push_back(30'({t[0], c}));
      wr(8'hB0, 8'h00, 1'b1);
      if (c != 4'hF)
        irq_q.push_back(30'({t[0], ~t[0]}));
      psel = c == 4'hF ? 4'h2 : c;
      plen = 4'(t + 1);
      step();
      fire = 1'b1;
      step();
      fire = 1'b0;
      for (int k = 0; k < 12 && irq_q.size() > 0; k++)
        step();
      if (irq_q.size() > 0) begin
        num_errors++;
        give_verdict();
      end
      repeat (6) step();
    end
    $display("interrupt test done");
    give_verdict();
  end
endmodule
